// >>> hdl/swf_core.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Result is file register minus working register, 8-bit two's complement.
// - Destination bit 0 stores the result in the working register only.
// - Destination bit 1, the default, writes the result back to the file register.
// - Bank bit 0 uses the access bank, or index_base plus offset if ext_set_en is set and offset <= 0x5f; 1 uses the bank selector.
// - A zero result sets zero flag and carry flag, meaning no borrow.
module swf_core (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic exec,
    input wire logic [7:0] file_addr,
    input wire logic dest_sel,
    input wire logic bank_acc,
    input wire logic ext_set_en,
    input wire logic [3:0] bank_selector,
    input wire logic [11:0] index_base,
    input wire logic [7:0] file_rdata,
    output logic [11:0] data_addr,
    output logic [7:0] file_wdata,
    output logic file_we,
    output logic [7:0] work_reg,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic ovf_flag,
    output logic neg_flag,
    output logic done
);

////////////////////////////////////////////////////////////////////////////////
// Helper functions.

    // Subtraction is done as minuend plus inverted subtrahend plus one, so the
    // ninth bit reads directly as "no borrow" and needs no separate compare.
    // The same helper serves the whole byte and the low nibble.
    function automatic logic [8:0] sub_no_borrow(
        input logic [7:0] minuend,
        input logic [7:0] subtrahend
    );
        sub_no_borrow = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    endfunction

    // Signed overflow can only happen when the operands differ in sign and
    // the result then loses the sign of the minuend.
    function automatic logic sub_overflow(
        input logic [7:0] minuend,
        input logic [7:0] subtrahend,
        input logic [7:0] result
    );
        sub_overflow = (minuend[7] != subtrahend[7]) && (result[7] != minuend[7]);
    endfunction

    // The bank bit takes priority, then the literal offset window, then the
    // split access bank; the order matters because the windows overlap.
    function automatic logic [11:0] form_addr(
        input logic [7:0] offset,
        input logic use_bank,
        input logic ext_on,
        input logic [3:0] bank,
        input logic [11:0] base
    );
        if (use_bank)
            form_addr = {bank, offset};
        else if (ext_on && (offset <= swf_pkg::LIT_OFS_MAX))
            form_addr = base + {4'h0, offset};
        else if (offset < swf_pkg::ACCESS_SPLIT)
            form_addr = {swf_pkg::ACCESS_LOW_BANK, offset};
        else
            form_addr = {swf_pkg::ACCESS_HIGH_BANK, offset};
    endfunction

////////////////////////////////////////////////////////////////////////////////
// State and next-state signals.

    logic [11:0] data_addr_r;
    logic [11:0] data_addr_nxt;
    logic [7:0] work_r;
    logic [7:0] work_nxt;
    logic [7:0] file_wdata_r;
    logic [7:0] file_wdata_nxt;
    logic file_we_r;
    logic file_we_nxt;
    logic c_r;
    logic c_nxt;
    logic dc_r;
    logic dc_nxt;
    logic z_r;
    logic z_nxt;
    logic ov_r;
    logic ov_nxt;
    logic n_r;
    logic n_nxt;
    logic done_r;
    logic done_nxt;

    // Operand decode results, shared by the groups below.
    logic [11:0] addr_now;
    logic [8:0] byte_diff;
    logic [8:0] nib_diff;
    logic [7:0] res;

////////////////////////////////////////////////////////////////////////////////
// Operand decode.

    // The address is formed without a register so that the file read can
    // finish in the instruction's own cycle; the registered copy on data_addr
    // is one cycle late and is meant for the write-back only.
    always_comb
    begin
        addr_now = form_addr(file_addr, bank_acc, ext_set_en, bank_selector, index_base);
        byte_diff = sub_no_borrow(file_rdata, work_r);
        nib_diff = sub_no_borrow({4'h0, file_rdata[3:0]}, {4'h0, work_r[3:0]});
        res = byte_diff[7:0];
    end

////////////////////////////////////////////////////////////////////////////////
// Address register.

    // The copy is refreshed on every cycle, not only on an instruction, so it
    // always pairs with the write strobe of the instruction just executed.
    always_comb
    begin
        data_addr_nxt = addr_now;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            data_addr_r <= swf_pkg::ADDR_RST;
        else
            data_addr_r <= data_addr_nxt;
    end

////////////////////////////////////////////////////////////////////////////////
// Result routing.

    always_comb
    begin
        work_nxt = work_r;
        file_wdata_nxt = file_wdata_r;
        file_we_nxt = swf_pkg::STROBE_RST;
        if (exec)
        begin
            if (dest_sel)
            begin
                file_wdata_nxt = res;
                file_we_nxt = 1'b1;
            end
            else
            begin
                work_nxt = res;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            work_r <= swf_pkg::W_RST;
            file_wdata_r <= swf_pkg::WDATA_RST;
            file_we_r <= swf_pkg::STROBE_RST;
        end
        else
        begin
            work_r <= work_nxt;
            file_wdata_r <= file_wdata_nxt;
            file_we_r <= file_we_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Status flags.

    // Flags hold their value between instructions; every instruction updates
    // all five together, whatever its destination.
    always_comb
    begin
        c_nxt = c_r;
        dc_nxt = dc_r;
        z_nxt = z_r;
        ov_nxt = ov_r;
        n_nxt = n_r;
        if (exec)
        begin
            c_nxt = byte_diff[8];
            dc_nxt = nib_diff[8];
            z_nxt = (res == 8'h00);
            ov_nxt = sub_overflow(file_rdata, work_r, res);
            n_nxt = res[7];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            c_r <= swf_pkg::FLAG_RST;
            dc_r <= swf_pkg::FLAG_RST;
            z_r <= swf_pkg::FLAG_RST;
            ov_r <= swf_pkg::FLAG_RST;
            n_r <= swf_pkg::FLAG_RST;
        end
        else
        begin
            c_r <= c_nxt;
            dc_r <= dc_nxt;
            z_r <= z_nxt;
            ov_r <= ov_nxt;
            n_r <= n_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Completion strobe.

    always_comb
    begin
        done_nxt = exec;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            done_r <= swf_pkg::STROBE_RST;
        else
            done_r <= done_nxt;
    end

////////////////////////////////////////////////////////////////////////////////
// Outputs, each taken straight from its flip-flop.

    assign data_addr = data_addr_r;
    assign file_wdata = file_wdata_r;
    assign file_we = file_we_r;
    assign work_reg = work_r;
    assign carry_flag = c_r;
    assign digit_carry_flag = dc_r;
    assign zero_flag = z_r;
    assign ovf_flag = ov_r;
    assign neg_flag = n_r;
    assign done = done_r;

endmodule
`default_nettype wire

// >>> hdl/swf_pkg.sv
package swf_pkg;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 8;
    localparam int BANK_W = 4;
    localparam int ADDR_W = 12;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic STROBE_RST = 1'b0;
    localparam logic [11:0] ADDR_RST = 12'h000;
    localparam logic [7:0] WDATA_RST = 8'h00;
    localparam logic [7:0] LIT_OFS_MAX = 8'h5f;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam int EXEC_CYCLES = 1;
endpackage

// >>> verification/swf_core_bench.sv
`timescale 1ns/100ps
`default_nettype none
module swf_core_bench;
    logic clock, rst_n, exec, dest_sel, bank_acc, ext_set_en, file_we, carry_flag, digit_carry_flag;
    logic zero_flag, ovf_flag, neg_flag, done;
    logic [7:0] file_addr, file_rdata, file_wdata, work_reg;
    logic [3:0] bank_selector;
    logic [11:0] index_base, data_addr;
    int mismatches, n_tests;
    swf_core dut_u (
        .clock(clock),
        .rst_n(rst_n),
        .exec(exec),
        .file_addr(file_addr),
        .dest_sel(dest_sel),
        .bank_acc(bank_acc),
        .ext_set_en(ext_set_en),
        .bank_selector(bank_selector),
        .index_base(index_base),
        .file_rdata(file_rdata),
        .data_addr(data_addr),
        .file_wdata(file_wdata),
        .file_we(file_we),
        .work_reg(work_reg),
        .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag),
        .ovf_flag(ovf_flag),
        .neg_flag(neg_flag),
        .done(done)
    );
    task chk(input string n, input logic [15:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    // Operands stay put after exec, so the delayed address copy still shows them.
    task op(input logic [7:0] f, r, input logic d, a, x);
        {exec, file_addr, file_rdata, dest_sel, bank_acc, ext_set_en} = {1'h1, f, r, d, a, x};
        repeat (swf_pkg::EXEC_CYCLES) @(negedge clock);
        exec = 1'h0;
        // The strobes stand for one cycle only, so they are looked at here.
        chk("we", {done, file_we}, {1'h1, d});
        @(negedge clock);
        chk("strobe", {done, file_we}, 2'h0);
    endtask
    task t_dest;
        op(8'h01, 8'h02, 1'h0, 1'h0, 1'h0);
        chk("w", work_reg, 8'h02);
        op(8'h01, 8'h03, 1'h1, 1'h0, 1'h0);
        chk("fw", {file_wdata, work_reg}, 16'h0102);
        chk("pos", {carry_flag, zero_flag, neg_flag, ovf_flag, digit_carry_flag}, 5'h11);
        op(8'h01, 8'h02, 1'h0, 1'h0, 1'h0);
        chk("zc", {zero_flag, carry_flag, work_reg}, 16'h0300);
        op(8'h01, 8'h01, 1'h0, 1'h0, 1'h0);
        op(8'h01, 8'h80, 1'h1, 1'h0, 1'h0);
        chk("ovf", {file_wdata, work_reg}, 16'h7f01);
        chk("ovff", {carry_flag, zero_flag, neg_flag, ovf_flag, digit_carry_flag}, 5'h12);
        op(8'h01, 8'h00, 1'h1, 1'h0, 1'h0);
        chk("neg", {file_wdata, work_reg}, 16'hff01);
        chk("negf", {carry_flag, zero_flag, neg_flag, ovf_flag, digit_carry_flag}, 5'h04);
        $display("t_dest end");
    endtask
    task t_addr;
        {bank_selector, index_base} = {4'h3, 12'h100};
        op(8'h10, 8'h00, 1'h0, 1'h1, 1'h0);
        chk("ba", data_addr, 16'h0310);
        op(8'h70, 8'h00, 1'h0, 1'h0, 1'h1);
        chk("aa", data_addr, 16'h0f70);
        op(8'h5f, 8'h00, 1'h0, 1'h0, 1'h1);
        chk("lo", data_addr, 16'h015f);
        op(8'h20, 8'h00, 1'h0, 1'h0, 1'h0);
        chk("al", data_addr, 16'h0020);
        op(8'h60, 8'h00, 1'h0, 1'h0, 1'h1);
        chk("lb", data_addr, 16'h0f60);
        $display("t_addr end");
    endtask
    // A mid-run reset must clear what earlier tests left, and an instruction on
    // the first edge after release must already see the cleared register.
    task t_reset;
        rst_n = 1'h0;
        @(negedge clock);
        chk("rst_ad", data_addr, swf_pkg::ADDR_RST);
        chk("rst_w", {file_wdata, work_reg}, {swf_pkg::WDATA_RST, swf_pkg::W_RST});
        chk("rst_f", {carry_flag, zero_flag, neg_flag, ovf_flag, digit_carry_flag, done, file_we}, 7'h00);
        rst_n = 1'h1;
        op(8'h00, 8'h05, 1'h0, 1'h0, 1'h0);
        chk("w_rel", work_reg, 8'h05);
        $display("t_reset end");
    endtask
    task stop_test;
        $display("mismatches %0d checks %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        {rst_n, exec, file_addr, file_rdata, dest_sel, bank_acc, ext_set_en, bank_selector, index_base} = '0;
        mismatches = 0;
        n_tests = 0;
        repeat (6) @(negedge clock);
        rst_n = 1'h1;
        t_dest;
        t_reset;
        t_addr;
        stop_test;
    end
endmodule
`default_nettype wire

// >>> verification/swf_core_props.sv
`timescale 1ns/100ps
`default_nettype none
module swf_core_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic exec,
    input wire logic [7:0] file_addr,
    input wire logic dest_sel,
    input wire logic bank_acc,
    input wire logic ext_set_en,
    input wire logic [3:0] bank_selector,
    input wire logic [11:0] index_base,
    input wire logic [7:0] file_rdata,
    input wire logic [11:0] data_addr,
    input wire logic [7:0] file_wdata,
    input wire logic file_we,
    input wire logic [7:0] work_reg,
    input wire logic carry_flag,
    input wire logic zero_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [7:0] res;
    always_ff @(posedge clock) res <= file_rdata - work_reg;
    chk_w_dest: assert property (exec && !dest_sel |=> !file_we && work_reg == res) else $error("W");
    chk_f_dest: assert property (exec && dest_sel |=> file_we && file_wdata == res && $stable(work_reg))
        else $error("f");
    chk_zero_c: assert property (exec && file_rdata == work_reg |=> zero_flag && carry_flag) else $error("z");
    chk_bank_ad: assert property (exec && bank_acc |=> data_addr == {$past(bank_selector), $past(file_addr)})
        else $error("b");
    chk_acc_ad: assert property (exec && !bank_acc && !ext_set_en |=> data_addr[11:8] == {4{$past(file_addr) > 8'h5f}})
        else $error("a");
    chk_lit_ofs: assert property (exec && !bank_acc && ext_set_en && file_addr < 8'h60
        |=> data_addr == $past(index_base) + $past(file_addr)) else $error("x");
    cover property (exec && dest_sel);
    cover property (exec && !dest_sel);
    cover property (exec && ext_set_en);
    cover property (exec && bank_acc);
endmodule
bind swf_core swf_core_props chk_u (
    .clock(clock),
    .rst_n(rst_n),
    .exec(exec),
    .file_addr(file_addr),
    .dest_sel(dest_sel),
    .bank_acc(bank_acc),
    .ext_set_en(ext_set_en),
    .bank_selector(bank_selector),
    .index_base(index_base),
    .file_rdata(file_rdata),
    .data_addr(data_addr),
    .file_wdata(file_wdata),
    .file_we(file_we),
    .work_reg(work_reg),
    .carry_flag(carry_flag),
    .zero_flag(zero_flag)
);
`default_nettype wire
